// >>> testbench/mhb_bank_assertions.sv
/*
  Port-level checks for the oscillator hopping bank.
  Assumes it is bound to mhb_bank and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mhb_bank_assertions
  import mhb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Samples and mixer
  input wire logic signed [mhb_pkg::ADC_W-1:0] adc_a_i,
  input wire logic signed [mhb_pkg::ADC_W-1:0] adc_b_i,
  input wire mhb_pkg::mhb_iq_s mix_a_o,
  input wire mhb_pkg::mhb_iq_s mix_b_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  wire req = avs_read_i | avs_write_i;
  logic [5:0] za_q;
  logic [5:0] zb_q;
  // Largest product of a full-scale sample and the 2047 amplitude
  function automatic logic ok(input logic signed [15:0] v);
    return v <= 16'sh3FF8 && v >= -16'sh3FF8;
  endfunction
  wire rng_ok = ok(mix_a_o.i) && ok(mix_a_o.q) && ok(mix_b_o.i) && ok(mix_b_o.q);
  // Runs of zero samples, saturating so they never wrap back
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      za_q <= 6'h00;
      zb_q <= 6'h00;
    end else begin
      za_q <= (adc_a_i != 0) ? 6'h00 : za_q + 6'((za_q != 6'h3F));
      zb_q <= (adc_b_i != 0) ? 6'h00 : zb_q + 6'((zb_q != 6'h3F));
    end
  end
  AST_WAIT_IDLE: assert property (!req |-> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  AST_WAIT_ACK: assert property ($rose(req) |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  AST_ACK_REQ: assert property (!avs_waitrequest_o |-> req && $past(req))
    else $error("answer without a held request");
  AST_RD_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved outside a read");
  AST_MIX_A_ZERO: assert property (za_q >= 6'h25 |-> mix_a_o == 32'h0)
    else $error("channel A mixer nonzero for zero samples");
  AST_MIX_B_ZERO: assert property (zb_q >= 6'h25 |-> mix_b_o == 32'h0)
    else $error("channel B mixer nonzero for zero samples");
  AST_MIX_RANGE: assert property (rng_ok)
    else $error("mixer output beyond product range");
  COV_WR: cover property ($rose(avs_write_i));
  COV_RD: cover property ($rose(avs_read_i));
  COV_ZERO: cover property (za_q == 6'h25);
endmodule // mhb_bank_assertions
`default_nettype wire

// >>> testbench/mhb_sel_drv.sv
/*
  External logic driving the oscillator select pins.
  Assumes the bench gives the wanted selector; pins follow off the clock grid.
*/
`timescale 1ns/1ps
`default_nettype none
module mhb_sel_drv (
  // Wanted selectors
  input wire logic [1:0] sel_a_i,
  input wire logic [1:0] sel_b_i,
  // Select pins
  output logic a0_o,
  output logic a1_o,
  output logic b0_o,
  output logic b1_o
);
  // Skewed delays so the pins never move on a clock edge
  assign #3 {a1_o, a0_o} = sel_a_i;
  assign #7 {b1_o, b0_o} = sel_b_i;
endmodule // mhb_sel_drv
`default_nettype wire

// >>> testbench/tb_mhb_bank.sv
/*
  Self-checking bench for the hopping bank: register bus, field and pin
  hopping, resynchronization. Assumes the pin model and checker files.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_mhb_bank;
  import mhb_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rdo;
  logic [31:0] d;
  logic wrq;
  logic lnk = 1'b0;
  logic sref = 1'b0;
  logic signed [11:0] xa = 12'h000;
  logic signed [11:0] xb = 12'h000;
  mhb_iq_s ma;
  mhb_iq_s mb;
  logic [1:0] pa = 2'h0;
  logic [1:0] pb = 2'h0;
  logic [1:0] sa = 2'h0;
  logic [1:0] sb = 2'h0;
  logic [1:0] q;
  logic a0, a1, b0, b1;
  logic [15:0] lf = 16'h001A;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  mhb_bank dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wrq), .ch_a_select_pin0_i(a0),
    .ch_a_select_pin1_i(a1), .ch_b_select_pin0_i(b0), .ch_b_select_pin1_i(b1),
    .sysref_i(sref), .link_start_i(lnk), .adc_a_i(xa), .adc_b_i(xb),
    .mix_a_o(ma), .mix_b_o(mb));
  mhb_sel_drv far (.sel_a_i(pa), .sel_b_i(pb), .a0_o(a0), .a1_o(a1), .b0_o(b0),
    .b1_o(b1));
  initial forever #10 mclk_i = ~mclk_i;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Rounded rational word: round(2^26 * n / dv)
  function automatic logic [31:0] rat_word(input int n, input int dv);
    logic [63:0] t;
    t = ((64'(n) << 27) / 64'(dv) + 64'h1) >> 1;
    return t[31:0];
  endfunction
  // Quarter-turn oscillator; the table sits half a step past each quarter,
  // so 2047 scales to 2045 (cosine) and 100 (sine of the half step)
  function automatic mhb_iq_s em(input logic signed [11:0] x, input logic [1:0] k);
    logic signed [23:0] lv [4];
    logic signed [23:0] c;
    logic signed [23:0] s;
    lv = '{24'sd2045, -24'sd100, -24'sd2045, 24'sd100};
    c = x * lv[k];
    s = x * lv[k - 2'h1];
    em.i = c[23:8];
    em.q = s[23:8];
  endfunction
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge mclk_i);
    adr <= a;
    wd <= v;
    rd <= !w;
    wr <= w;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (wrq !== 1'b0 && k < 20);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20) fails++;
  endtask
  // Channel B phases run backwards, so its quarter is 3 minus the index
  task automatic step(input logic [1:0] qa, input logic [1:0] qb, input logic old);
    repeat (33) @(posedge mclk_i);
    if (old) chk({em(xa, sa), em(xb, 2'h3 - sb)}, {ma, mb});
    repeat (9) @(posedge mclk_i);
    chk({em(xa, qa), em(xb, 2'h3 - qb)}, {ma, mb});
    bus(0, STATUS_OFS, 0);
    chk(rdat, {28'h0, qb, qa});
    sa = qa;
    sb = qb;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    chk({wrq, rdo, ma, mb}, {1'b1, 96'h0});
    arst_n_i <= 1'b1;
    for (int a = 0; a < 'h54; a += 4) begin
      bus(0, 8'(a), 0);
      chk(rdat, 0);
    end
    for (int a = 8; a < 'h54; a += 4) begin
      lf = nx(lf);
      d = {lf, nx(lf)};
      bus(1, 8'(a), d);
      bus(0, 8'(a), 0);
      chk(rdat, a >= 'h50 ? 0 : (a < 'h10 || a >= 'h30) ? d & 32'hFFFF : d);
    end
    bus(1, STATUS_OFS, 32'hFFFFFFFF);
    bus(0, STATUS_OFS, 0);
    chk(rdat, 0);
    for (int k = 0; k < 4; k++) begin
      bus(1, FREQ_A_OFS + 8'(4 * k), 0);
      bus(1, FREQ_B_OFS + 8'(4 * k), 0);
      bus(1, PHASE_A_OFS + 8'(4 * k), 32'(k) << 14);
      bus(1, PHASE_B_OFS + 8'(4 * k), 32'(3 - k) << 14);
    end
    bus(1, RDIV_A_OFS, 0);
    bus(1, RDIV_B_OFS, 0);
    bus(1, CTRL_OFS, 32'h20);
    bus(0, STATUS_OFS, 0);
    chk(rdat[4], 1'b1);
    @(posedge mclk_i) sref <= 1'b1;
    repeat (8) @(posedge mclk_i);
    sref <= 1'b0;
    bus(0, STATUS_OFS, 0);
    chk(rdat[4], 1'b0);
    bus(1, CTRL_OFS, 32'h40);
    @(posedge mclk_i) lnk <= 1'b1;
    @(posedge mclk_i) lnk <= 1'b0;
    lf = nx(lf);
    xa <= lf[11:0];
    xb <= lf[15:4];
    for (int k = 0; k < 4; k++) begin
      bus(1, CTRL_OFS, (32'(k) << 1) | (32'(3 - k) << 3));
      step(2'(k), 2'(3 - k), 1'b0);
    end
    bus(1, CTRL_OFS, 32'h1F);
    step(2'h0, 2'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      @(posedge mclk_i);
      pa <= i < 4 ? 2'(i) : sa + 2'(1 + lf[0]);
      pb <= i < 4 ? 2'(3 - i) : sb + 2'(1 + lf[1]);
      @(posedge mclk_i);
      step(pa, pb, 1'b1);
    end
    bus(1, CTRL_OFS, 32'h0C);
    pa <= ~pa;
    step(2'h2, 2'h1, 1'b0);
    // Quarter-turn word: the output must rotate one quarter each cycle
    bus(1, FREQ_A_OFS + 8'h08, 32'h4000_0000);
    repeat (40) @(posedge mclk_i);
    q = 2'h0;
    for (int k = 0; k < 4; k++) if (ma === em(xa, 2'(k))) q = 2'(k);
    repeat (6) begin
      @(posedge mclk_i);
      q = q + 2'h1;
      chk(ma, em(xa, q));
    end
    // Divisor 5 gives a 156.25 kHz grid; the word for N = 81 leaves a residue
    bus(1, RDIV_A_OFS, 32'h0000_0005);
    bus(1, FREQ_A_OFS + 8'h08, rat_word(81, 5));
    bus(1, CTRL_OFS, 32'h4C);
    @(posedge mclk_i) lnk <= 1'b1;
    @(posedge mclk_i) lnk <= 1'b0;
    repeat (3) @(posedge mclk_i);
    // Every 80 cycles the exact mean step has turned 81 quarters, one quarter net
    for (int m = 0; m < 4; m++) begin
      chk(ma, em(xa, 2'(m + 2)));
      repeat (80) @(posedge mclk_i);
    end
    conclude();
  end
endmodule // tb_mhb_bank
bind mhb_bank mhb_bank_assertions chk_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .adc_a_i(adc_a_i), .adc_b_i(adc_b_i),
  .mix_a_o(mix_a_o), .mix_b_o(mix_b_o));
`default_nettype wire

// >>> verilog/mhb_bank.sv
/*
  Dual-channel oscillator hopping bank with complex mixer and Avalon-MM
  register slave. Assumes real samples and the reference pulse arrive on the
  device clock or as async pins; select pins are fully asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module mhb_bank (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [mhb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Asynchronous select pins
  input wire logic ch_a_select_pin0_i,
  input wire logic ch_a_select_pin1_i,
  input wire logic ch_b_select_pin0_i,
  input wire logic ch_b_select_pin1_i,
  // Resynchronization sources
  input wire logic sysref_i,
  input wire logic link_start_i,
  // Real samples in, complex mixer out
  input wire logic signed [mhb_pkg::ADC_W-1:0] adc_a_i,
  input wire logic signed [mhb_pkg::ADC_W-1:0] adc_b_i,
  output mhb_pkg::mhb_iq_s mix_a_o,
  output mhb_pkg::mhb_iq_s mix_b_o
);
  import mhb_pkg::*;

  // Quarter-wave sine, 16 points at half-step offsets, amplitude 2047
  function automatic logic [11:0] quarter_sine(input logic [3:0] idx);
    logic [11:0] v;
    v = 12'h000;
    case (idx)
      4'h0: v = 12'h064;
      4'h1: v = 12'h12C;
      4'h2: v = 12'h1F1;
      4'h3: v = 12'h2B2;
      4'h4: v = 12'h36B;
      4'h5: v = 12'h41C;
      4'h6: v = 12'h4C3;
      4'h7: v = 12'h55F;
      4'h8: v = 12'h5ED;
      4'h9: v = 12'h66C;
      4'hA: v = 12'h6DC;
      4'hB: v = 12'h73A;
      4'hC: v = 12'h787;
      4'hD: v = 12'h7C2;
      4'hE: v = 12'h7E9;
      default: v = 12'h7FD;
    endcase
    return v;
  endfunction

  // Signed sine of a 6-bit phase; quadrant picks mirror and sign
  function automatic logic signed [12:0] sine6(input logic [5:0] ph);
    logic [11:0] mag;
    mag = ph[4] ? quarter_sine(~ph[3:0]) : quarter_sine(ph[3:0]);
    return ph[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  // Mixer product scaled to the output width
  function automatic logic signed [MIX_W-1:0] mix_mul(input logic signed [ADC_W-1:0] s,
                                                      input logic signed [12:0] lo);
    logic signed [24:0] p;
    p = s * lo;
    return p[23:8];
  endfunction

  // Correction numerator: 2^26*N - word*divisor with N rounded
  function automatic logic signed [17:0] rat_err(input logic [31:0] fw,
                                                 input logic [15:0] rdiv);
    logic [47:0] prod;
    logic [47:0] n;
    logic [49:0] diff;
    prod = fw * rdiv;
    n = (prod + RAT_HALF) >> RAT_SHIFT;
    diff = {2'b00, n << RAT_SHIFT} - {2'b00, prod};
    return diff[17:0];
  endfunction

  // Register state
  logic [6:0] ctrl_q;
  logic [15:0] rdiv_q [NUM_CH];
  logic [31:0] freq_q [NUM_CH][NUM_OSC];
  logic [15:0] phase_q [NUM_CH][NUM_OSC];
  logic wait_q;
  logic [31:0] rdata_q;

  // Oscillator state
  logic [31:0] acc_q [NUM_CH][NUM_OSC];
  logic signed [17:0] err_q [NUM_CH][NUM_OSC];
  logic [31:0] acc_d [NUM_CH][NUM_OSC];
  logic signed [17:0] err_d [NUM_CH][NUM_OSC];

  // Selection pipeline
  logic [SYNC_LEN-1:0] pin_sync_q [NUM_CH][2];
  mhb_sel_t hop_dly_q [NUM_CH][HOP_DLY_LEN];
  logic signed [ADC_W-1:0] adc_dly_q [NUM_CH][ADC_DLY_LEN];
  mhb_sel_t active_sel [NUM_CH];
  logic [5:0] lo_ph_q [NUM_CH];
  mhb_iq_s mix_q [NUM_CH];

  // Resynchronization
  logic [SYNC_LEN-1:0] ref_sync_q;
  logic ref_last_q;

  // Bus decode
  wire logic bus_req = avs_read_i | avs_write_i;
  wire logic wr_fire = avs_write_i & ~wait_q;
  wire logic hit_ctrl = (avs_address_i == CTRL_OFS);
  wire logic hit_status = (avs_address_i == STATUS_OFS);
  wire logic hit_rdiv_a = (avs_address_i == RDIV_A_OFS);
  wire logic hit_rdiv_b = (avs_address_i == RDIV_B_OFS);
  wire logic [ADDR_W-1:0] bank_base = {avs_address_i[ADDR_W-1:4], 4'h0};
  wire logic [1:0] bank_osc = avs_address_i[3:2];
  wire logic hit_freq_a = (bank_base == FREQ_A_OFS);
  wire logic hit_freq_b = (bank_base == FREQ_B_OFS);
  wire logic hit_phase_a = (bank_base == PHASE_A_OFS);
  wire logic hit_phase_b = (bank_base == PHASE_B_OFS);
  wire logic [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // Reference edge and link start resynchronize every accumulator
  wire logic ref_rise = ref_sync_q[SYNC_LEN-1] & ~ref_last_q;
  wire logic ref_sync_ev = ref_rise & ctrl_q[ARM_BIT];
  wire logic link_sync_ev = link_start_i & ctrl_q[LINK_SYNC_BIT];
  wire logic resync = ref_sync_ev | link_sync_ev;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
    return (old & ~mask) | (avs_writedata_i & mask);
  endfunction

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = {25'h000_0000, ctrl_q};
    end else if (hit_status) begin
      rd_mux = {27'h000_0000, ctrl_q[ARM_BIT], active_sel[1], active_sel[0]};
    end else if (hit_rdiv_a) begin
      rd_mux = {16'h0000, rdiv_q[0]};
    end else if (hit_rdiv_b) begin
      rd_mux = {16'h0000, rdiv_q[1]};
    end else if (hit_freq_a) begin
      rd_mux = freq_q[0][bank_osc];
    end else if (hit_freq_b) begin
      rd_mux = freq_q[1][bank_osc];
    end else if (hit_phase_a) begin
      rd_mux = {16'h0000, phase_q[0][bank_osc]};
    end else if (hit_phase_b) begin
      rd_mux = {16'h0000, phase_q[1][bank_osc]};
    end
  end

  // Handshake: waitrequest drops one cycle after the request, then rises again
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (avs_read_i & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Control register; arm is cleared by a reference edge unless rewritten then
  logic [6:0] ctrl_wr;
  logic [6:0] ctrl_d;
  always_comb begin
    ctrl_wr = 7'(merge({25'h000_0000, ctrl_q}, be_mask));
    ctrl_d = ctrl_q;
    if (ref_sync_ev) begin
      ctrl_d[ARM_BIT] = 1'b0;
    end
    if (wr_fire & hit_ctrl) begin
      ctrl_d = ctrl_wr;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Per-oscillator words, channel B mirrors channel A
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rdiv_q[c] <= RDIV_RST;
        for (int k = 0; k < NUM_OSC; k++) begin
          freq_q[c][k] <= FREQ_RST;
          phase_q[c][k] <= PHASE_RST;
        end
      end
    end else if (wr_fire) begin
      if (hit_rdiv_a) rdiv_q[0] <= 16'(merge({16'h0000, rdiv_q[0]}, be_mask));
      if (hit_rdiv_b) rdiv_q[1] <= 16'(merge({16'h0000, rdiv_q[1]}, be_mask));
      if (hit_freq_a) freq_q[0][bank_osc] <= merge(freq_q[0][bank_osc], be_mask);
      if (hit_freq_b) freq_q[1][bank_osc] <= merge(freq_q[1][bank_osc], be_mask);
      if (hit_phase_a) begin
        phase_q[0][bank_osc] <= 16'(merge({16'h0000, phase_q[0][bank_osc]}, be_mask));
      end
      if (hit_phase_b) begin
        phase_q[1][bank_osc] <= 16'(merge({16'h0000, phase_q[1][bank_osc]}, be_mask));
      end
    end
  end

  // Accumulator next state. Rational mode carries a residue modulo the
  // divisor and adds or drops one count on wrap, so the mean step is exact.
  // The residue stays bounded only while words follow the rounding formula.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      for (int k = 0; k < NUM_OSC; k++) begin
        logic signed [18:0] e_sum;
        logic signed [18:0] rdiv_s;
        logic [31:0] inc;
        e_sum = 19'sh0_0000;
        rdiv_s = $signed({3'b000, rdiv_q[c]});
        inc = freq_q[c][k];
        err_d[c][k] = 18'sh0_0000;
        if (rdiv_q[c] != RDIV_RST) begin
          e_sum = err_q[c][k] + rat_err(freq_q[c][k], rdiv_q[c]);
          if (e_sum >= rdiv_s) begin
            e_sum = e_sum - rdiv_s;
            inc = freq_q[c][k] + 32'h0000_0001;
          end else if (e_sum < 19'sh0_0000) begin
            e_sum = e_sum + rdiv_s;
            inc = freq_q[c][k] - 32'h0000_0001;
          end
          err_d[c][k] = e_sum[17:0];
        end
        acc_d[c][k] = acc_q[c][k] + inc;
        if (resync) begin
          acc_d[c][k] = 32'h0000_0000;
          err_d[c][k] = 18'sh0_0000;
        end
      end
    end
  end

  // Every accumulator runs each cycle whether selected or not
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < NUM_OSC; k++) begin
          acc_q[c][k] <= 32'h0000_0000;
          err_q[c][k] <= 18'sh0_0000;
        end
      end
    end else begin
      acc_q <= acc_d;
      err_q <= err_d;
    end
  end

  // Pins and reference are asynchronous: two flops before any logic
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        pin_sync_q[c][0] <= '0;
        pin_sync_q[c][1] <= '0;
      end
      ref_sync_q <= '0;
      ref_last_q <= 1'b0;
    end else begin
      pin_sync_q[0][0] <= {pin_sync_q[0][0][0], ch_a_select_pin0_i};
      pin_sync_q[0][1] <= {pin_sync_q[0][1][0], ch_a_select_pin1_i};
      pin_sync_q[1][0] <= {pin_sync_q[1][0][0], ch_b_select_pin0_i};
      pin_sync_q[1][1] <= {pin_sync_q[1][1][0], ch_b_select_pin1_i};
      ref_sync_q <= {ref_sync_q[0], sysref_i};
      ref_last_q <= ref_sync_q[SYNC_LEN-1];
    end
  end

  // Hop delay line and sample delay line line the hop up with the data path
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int s = 0; s < HOP_DLY_LEN; s++) hop_dly_q[c][s] <= 2'h0;
        for (int s = 0; s < ADC_DLY_LEN; s++) adc_dly_q[c][s] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        hop_dly_q[c][0] <= {pin_sync_q[c][1][SYNC_LEN-1], pin_sync_q[c][0][SYNC_LEN-1]};
        for (int s = 1; s < HOP_DLY_LEN; s++) hop_dly_q[c][s] <= hop_dly_q[c][s-1];
        for (int s = 1; s < ADC_DLY_LEN; s++) adc_dly_q[c][s] <= adc_dly_q[c][s-1];
      end
      adc_dly_q[0][0] <= adc_a_i;
      adc_dly_q[1][0] <= adc_b_i;
    end
  end

  // Source choice: pins when the mode bit is set, register field otherwise
  assign active_sel[0] = ctrl_q[MODE_BIT] ? hop_dly_q[0][HOP_DLY_LEN-1]
                                          : ctrl_q[SEL_A_LSB +: 2];
  assign active_sel[1] = ctrl_q[MODE_BIT] ? hop_dly_q[1][HOP_DLY_LEN-1]
                                          : ctrl_q[SEL_B_LSB +: 2];

  // Selected phase with offset left-justified; binary index picks the pair
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) lo_ph_q[c] <= 6'h00;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        lo_ph_q[c] <= 6'((acc_q[c][active_sel[c]] +
                          {phase_q[c][active_sel[c]], 16'h0000}) >> 26);
      end
    end
  end

  // Complex mixer; the coarse table limits spur performance, traded for area
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) mix_q[c] <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        mix_q[c].i <= mix_mul(adc_dly_q[c][ADC_DLY_LEN-1], sine6(lo_ph_q[c] + 6'h10));
        mix_q[c].q <= mix_mul(adc_dly_q[c][ADC_DLY_LEN-1], sine6(lo_ph_q[c]));
      end
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign mix_a_o = mix_q[0];
  assign mix_b_o = mix_q[1];

endmodule // mhb_bank
`default_nettype wire

// >>> verilog/mhb_pkg.sv
/*
  Shared constants and types for the oscillator hopping bank: register map,
  control field positions, reset values, pipeline lengths and sample types.
  Assumes a 50 MHz device clock and a word-aligned Avalon-MM register bus.
*/
// What this block does
// - Four independently programmed oscillators per channel.
// - All accumulators advance always, selected or not.
// - Select pin change switches the channel mixer.
// - Select pins sampled asynchronously; hop timing approximate.
// - Pin to mixer about 36-37 cycles.
// - Mode bit picks pins (1) or field (0).
// - Two-bit selector decodes binary to oscillator index.
// - Divisor zero: output equals word times clock/2^32.
// - Nonzero divisor: exact frequencies on step grid.
// - Phase word left-justified, added to accumulator.
// - Words exist per accumulator, channel B mirrors A.
// - Selected complex oscillator multiplies real samples.
// - Resynchronize on link start or armed reference.
package mhb_pkg;

  localparam int NUM_CH = 2;
  localparam int NUM_OSC = 4;
  localparam int ADC_W = 12;
  localparam int MIX_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RDIV_A_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] RDIV_B_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FREQ_A_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] FREQ_B_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] PHASE_A_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] PHASE_B_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] BANK_SPAN = 8'h10;

  // Control register fields
  localparam int MODE_BIT = 0;
  localparam int SEL_A_LSB = 1;
  localparam int SEL_B_LSB = 3;
  localparam int ARM_BIT = 5;
  localparam int LINK_SYNC_BIT = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // Status register fields
  localparam int ST_SEL_A_LSB = 0;
  localparam int ST_SEL_B_LSB = 2;
  localparam int ST_ARM_BIT = 4;

  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [15:0] RDIV_RST = 16'h0000;

  // Pipeline lengths: 2 sync + 32 hop delay + phase + output = 36 cycles
  localparam int SYNC_LEN = 2;
  localparam int HOP_DLY_LEN = 32;
  localparam int ADC_DLY_LEN = 35;

  // Rational mode rounding
  localparam int RAT_SHIFT = 26;
  localparam logic [47:0] RAT_HALF = 48'h0000_0200_0000;

  typedef logic [1:0] mhb_sel_t;

  typedef struct packed {
    logic signed [MIX_W-1:0] i;
    logic signed [MIX_W-1:0] q;
  } mhb_iq_s;

endpackage : mhb_pkg
